// ==== i2cfr_bus_model.sv ====
// Other bus parties on the two open-drain lines, with pull-ups
`timescale 1ns/10ps
module i2cfr_bus_model (
  input  logic mclk,
  input  logic scl_oe,
  input  logic sda_oe,
  output logic scl_line,
  output logic sda_line
);
  logic ext_scl_low;
  logic ext_sda_low;
  initial begin
    ext_scl_low = 1'b0;
    ext_sda_low = 1'b0;
  end
  // Wired AND: any party pulling low wins, pull-up otherwise
  assign scl_line = !(scl_oe || ext_scl_low);
  assign sda_line = !(sda_oe || ext_sda_low);
  ////////////////////////////////////////////////////////////////////////////
  task automatic gen_stop;
    begin
      @(posedge mclk);
      ext_scl_low <= 1'b1;
      ext_sda_low <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_scl_low <= 1'b0;
      repeat (4) @(posedge mclk);
      ext_sda_low <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask
endmodule // i2cfr_bus_model

// ==== i2cfr_consts.vh ====
// Offsets, field positions, reset values, clock rate and hold times in ns of the I2C flag and clock-select registers
`ifndef I2CFR_CONSTS_VH
`define I2CFR_CONSTS_VH

// Register indexes; the Avalon word address equals the index, byte address is four times it
`define I2CFR_IDX_FLAG      32'h0ffffd8a
`define I2CFR_IDX_CLKSEL    32'hfffffd84
`define I2CFR_IDX_FUNCX     32'hfffffd85
`define I2CFR_IDX_CTRL      32'hfffffd86

// Bus flag register fields
`define I2CFR_FLAG_FAIL     7
`define I2CFR_FLAG_BUSY     6
`define I2CFR_FLAG_ISE      1
`define I2CFR_FLAG_RSV      0

// Transfer clock select register fields
`define I2CFR_CS_CLD        5
`define I2CFR_CS_DAD        4
`define I2CFR_CS_SMC        3
`define I2CFR_CS_DFC        2
`define I2CFR_CS_DIVHI      1
`define I2CFR_CS_DIVLO      0

// Function expansion register field
`define I2CFR_FX_CLX        0

// Control and status register fields
`define I2CFR_CT_OPEN       0
`define I2CFR_CT_TRIG       1
`define I2CFR_CT_STD        2
`define I2CFR_CT_SPD        3

// Reset values
`define I2CFR_RST_FLAG      8'h00
`define I2CFR_RST_CLKSEL    8'h00
`define I2CFR_RST_FUNCX     8'h00

// Timing
`define I2CFR_CLK_MHZ       100
`define I2CFR_HOLD_STD_NS   4000
`define I2CFR_HOLD_HS_NS    600

// Transfer clock divisors (fxx/m); zero marks a prohibited setting
`define I2CFR_M_88          8'h58
`define I2CFR_M_172         8'hac
`define I2CFR_M_86          8'h56
`define I2CFR_M_198         8'hc6
`define I2CFR_M_48          8'h30
`define I2CFR_M_24          8'h18
`define I2CFR_M_54          8'h36
`define I2CFR_M_12          8'h0c
`define I2CFR_M_NONE        8'h00

`endif

// ==== i2cfr_regs.v ====
// I2C bus flag, transfer clock select and function expansion registers with start generation
`timescale 1ns/10ps
`include "i2cfr_consts.vh"

module i2cfr_regs #(
  parameter HOLD_STD_NS = `I2CFR_HOLD_STD_NS,
  parameter HOLD_HS_NS  = `I2CFR_HOLD_HS_NS
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        ce,
  input  wire [31:0] avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        scl_in,
  output wire        scl_out,
  output reg         scl_oe,
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_oe,
  input  wire        engine_release,
  output reg         start_done,
  output reg  [7:0]  scl_divisor,
  output reg         filter_active
);

  // Hold counts round up so a start never holds shorter than asked
  // Counts above 1023 cycles wrap: widen cnt_r for slow pins or a faster clock
  localparam       HOLD_STD_RAW = (HOLD_STD_NS * `I2CFR_CLK_MHZ + 999) / 1000;
  localparam       HOLD_HS_RAW  = (HOLD_HS_NS * `I2CFR_CLK_MHZ + 999) / 1000;
  localparam [9:0] HOLD_STD_CYC = HOLD_STD_RAW[9:0];
  localparam [9:0] HOLD_HS_CYC  = HOLD_HS_RAW[9:0];

  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_HOLD = 2'b01;
  localparam [1:0] ST_OWN  = 2'b10;

  // Divisor table; the filter bit is deliberately not an argument
  function [7:0] div_of;
    input       clx;
    input       smc;
    input [1:0] sel;
    begin
      case ({clx, smc, sel})
        4'b0000: div_of = `I2CFR_M_88;
        4'b0001: div_of = `I2CFR_M_172;
        4'b0010: div_of = `I2CFR_M_86;
        4'b0011: div_of = `I2CFR_M_198;
        4'b0100: div_of = `I2CFR_M_48;
        4'b0101: div_of = `I2CFR_M_48;
        4'b0110: div_of = `I2CFR_M_24;
        4'b0111: div_of = `I2CFR_M_54;
        4'b1100: div_of = `I2CFR_M_24;
        4'b1101: div_of = `I2CFR_M_24;
        4'b1110: div_of = `I2CFR_M_12;
        default: div_of = `I2CFR_M_NONE;
      endcase
    end
  endfunction

  // Whole-word compare: a partial decode would alias the registers across the space
  function hit;
    input [31:0] addr;
    input [31:0] idx;
    begin
      hit = (addr == idx);
    end
  endfunction

  reg        ack_r;
  reg        fail_r;
  reg        busy_r;
  reg        ise_r;
  reg        rsv_r;
  reg        cld_r;
  reg        dad_r;
  reg        smc_r;
  reg        dfc_r;
  reg  [1:0] div_r;
  reg        clx_r;
  reg        open_r;
  reg        trig_r;
  reg        std_r;
  reg        spd_r;
  reg        raw_scl_r;
  reg        raw_sda_r;
  reg        f_scl_r;
  reg        f_sda_r;
  reg        p_scl_r;
  reg        p_sda_r;
  reg  [1:0] state_r;
  reg  [9:0] cnt_r;

  wire       req;
  wire       wr_go;
  wire       wr_flag;
  wire       wr_cs;
  wire       wr_fx;
  wire       wr_ct;
  wire       new_open;
  wire       en_rise;
  wire       en_fall;
  wire       trig_wr;
  wire       start_det;
  wire       stop_det;
  wire       hs_filt;
  wire       attempt;
  wire       fail_ev;
  wire [9:0] hold_cyc;

  ////////////////////////////////////////////////////////////////////////////
  // Request decode and bus events
  assign req       = avs_read | avs_write;
  assign wr_go     = avs_write & ack_r & avs_byteenable[0];
  assign wr_flag   = wr_go & hit(avs_address, `I2CFR_IDX_FLAG);
  assign wr_cs     = wr_go & hit(avs_address, `I2CFR_IDX_CLKSEL);
  assign wr_fx     = wr_go & hit(avs_address, `I2CFR_IDX_FUNCX);
  assign wr_ct     = wr_go & hit(avs_address, `I2CFR_IDX_CTRL);
  assign new_open  = wr_ct ? avs_writedata[`I2CFR_CT_OPEN] : open_r;
  assign en_rise   = new_open & ~open_r;
  assign en_fall   = ~new_open & open_r;
  assign trig_wr   = wr_ct & open_r & avs_writedata[`I2CFR_CT_TRIG];
  assign start_det = open_r & p_scl_r & f_scl_r & p_sda_r & ~f_sda_r;
  assign stop_det  = open_r & p_scl_r & f_scl_r & ~p_sda_r & f_sda_r;
  assign hs_filt   = smc_r & dfc_r;
  assign attempt   = (state_r == ST_IDLE) & trig_r & open_r;
  assign fail_ev   = attempt & busy_r & rsv_r;
  assign hold_cyc  = smc_r ? HOLD_HS_CYC : HOLD_STD_CYC;

  // One wait cycle per access: the answer comes on the second edge
  assign avs_waitrequest = req & ~ack_r;
  // Open-drain pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon slave answer
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_r        <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else if (ce) begin
      ack_r <= req & ~ack_r;
      if (avs_read & ~ack_r) begin
        case (avs_address)
          `I2CFR_IDX_FLAG:
            avs_readdata <= {24'h000000, fail_r, busy_r, 4'h0, ise_r, rsv_r};
          `I2CFR_IDX_CLKSEL:
            avs_readdata <= {24'h000000, 2'b00, cld_r, dad_r, smc_r, dfc_r, div_r};
          `I2CFR_IDX_FUNCX:
            avs_readdata <= {24'h000000, 7'h00, clx_r};
          `I2CFR_IDX_CTRL:
            avs_readdata <= {24'h000000, 4'h0, spd_r, std_r, trig_r, open_r};
          default:
            avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software settings; held still while the controller runs
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      rsv_r  <= |(`I2CFR_RST_FLAG & (8'h01 << `I2CFR_FLAG_RSV));
      smc_r  <= 1'b0;
      dfc_r  <= 1'b0;
      div_r  <= 2'b00;
      clx_r  <= 1'b0;
      open_r <= 1'b0;
    end else if (ce) begin
      open_r <= new_open;
      if (wr_flag & ~open_r)
        rsv_r <= avs_writedata[`I2CFR_FLAG_RSV];
      if (wr_cs & ~open_r) begin
        smc_r <= avs_writedata[`I2CFR_CS_SMC];
        dfc_r <= avs_writedata[`I2CFR_CS_DFC];
        div_r <= avs_writedata[`I2CFR_CS_DIVHI:`I2CFR_CS_DIVLO];
      end
      if (wr_fx & ~open_r)
        clx_r <= avs_writedata[`I2CFR_FX_CLX];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line sampling, optional two-sample filter, edge history
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      raw_scl_r <= 1'b1;
      raw_sda_r <= 1'b1;
      f_scl_r   <= 1'b1;
      f_sda_r   <= 1'b1;
      p_scl_r   <= 1'b1;
      p_sda_r   <= 1'b1;
      cld_r     <= 1'b0;
      dad_r     <= 1'b0;
      filter_active <= 1'b0;
      scl_divisor   <= `I2CFR_M_NONE;
    end else if (ce) begin
      raw_scl_r <= scl_in;
      raw_sda_r <= sda_in;
      // A filtered line follows only two equal samples in a row
      if (!hs_filt || raw_scl_r == scl_in)
        f_scl_r <= scl_in;
      if (!hs_filt || raw_sda_r == sda_in)
        f_sda_r <= sda_in;
      p_scl_r <= f_scl_r;
      p_sda_r <= f_sda_r;
      cld_r   <= open_r & f_scl_r;
      dad_r   <= open_r & f_sda_r;
      filter_active <= hs_filt;
      scl_divisor   <= div_of(clx_r, smc_r, div_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus state flags
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fail_r <= 1'b0;
      busy_r <= 1'b0;
      ise_r  <= 1'b0;
      std_r  <= 1'b0;
      spd_r  <= 1'b0;
    end else if (ce) begin
      if (en_fall) begin
        fail_r <= 1'b0;
        busy_r <= 1'b0;
        std_r  <= 1'b0;
        spd_r  <= 1'b0;
      end else begin
        // Failure event wins over a simultaneous trigger write
        if (fail_ev)
          fail_r <= 1'b1;
        else if (trig_wr)
          fail_r <= 1'b0;
        if (en_rise)
          busy_r <= ~ise_r;
        else if (start_det)
          busy_r <= 1'b1;
        else if (stop_det)
          busy_r <= 1'b0;
        if (start_det) begin
          std_r <= 1'b1;
          spd_r <= 1'b0;
        end else if (stop_det) begin
          spd_r <= 1'b1;
          std_r <= 1'b0;
        end
      end
      if (start_det)
        ise_r <= 1'b0;
      else if (wr_flag & ~open_r)
        ise_r <= avs_writedata[`I2CFR_FLAG_ISE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start generation; a busy bus either fails at once or waits as a reservation
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r    <= ST_IDLE;
      cnt_r      <= 10'h000;
      trig_r     <= 1'b0;
      scl_oe     <= 1'b0;
      sda_oe     <= 1'b0;
      start_done <= 1'b0;
    end else if (ce) begin
      start_done <= 1'b0;
      if (en_fall) begin
        state_r <= ST_IDLE;
        trig_r  <= 1'b0;
        scl_oe  <= 1'b0;
        sda_oe  <= 1'b0;
      end else begin
        if (trig_wr)
          trig_r <= 1'b1;
        case (state_r)
          ST_IDLE: begin
            if (attempt & ~busy_r) begin
              state_r <= ST_HOLD;
              sda_oe  <= 1'b1;
              cnt_r   <= hold_cyc;
            end else if (fail_ev) begin
              trig_r <= 1'b0;
            end
          end
          ST_HOLD: begin
            if (cnt_r == 10'h001) begin
              state_r    <= ST_OWN;
              scl_oe     <= 1'b1;
              trig_r     <= 1'b0;
              start_done <= 1'b1;
            end else begin
              cnt_r <= cnt_r - 10'h001;
            end
          end
          ST_OWN: begin
            // The shift engine takes the bus from here
            if (engine_release) begin
              state_r <= ST_IDLE;
              scl_oe  <= 1'b0;
              sda_oe  <= 1'b0;
            end
          end
          default: begin
            state_r <= ST_IDLE;
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // i2cfr_regs

// ==== i2cfr_regs_sva.sv ====
// Assertion checker for the I2C flag and clock-select register block
`timescale 1ns/10ps
module i2cfr_regs_sva (
  input logic        mclk,
  input logic        rst,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  input logic        scl_out,
  input logic        scl_oe,
  input logic        sda_out,
  input logic        sda_oe,
  input logic        engine_release,
  input logic        start_done,
  input logic [7:0]  scl_divisor
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held past one cycle");
  a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without a request");
  a_rd_upper: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  // Open drain: the pins may only ever be pulled low
  a_pins_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin driven high");
  a_start_order: assert property ($rose(scl_oe) |-> sda_oe && $past(sda_oe))
    else $error("clock pulled before data on start");
  a_hold_time: assert property ($rose(sda_oe) |-> !scl_oe [*8])
    else $error("start hold too short");
  a_done_pulse: assert property (start_done |-> sda_oe ##1 !start_done)
    else $error("start done not a single pulse");
  a_release: assert property (scl_oe && engine_release |=> !scl_oe && !sda_oe)
    else $error("pins not released");
  a_div_legal: assert property (scl_divisor inside {8'h58, 8'hac, 8'h56, 8'hc6, 8'h30, 8'h18, 8'h36, 8'h0c, 8'h00})
    else $error("divisor outside the table");
endmodule // i2cfr_regs_sva

bind i2cfr_regs i2cfr_regs_sva i_sva (.mclk(mclk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_out(sda_out), .sda_oe(sda_oe), .engine_release(engine_release), .start_done(start_done),
  .scl_divisor(scl_divisor));

// ==== testbench.sv ====
// Self-checking bench for the I2C flag and clock-select register block
`timescale 1ns/10ps
`include "i2cfr_consts.vh"
module testbench;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] avs_address = 32'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        scl_line, sda_line, scl_oe, sda_oe, start_done, filter_active;
  logic        engine_release = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  scl_divisor;
  integer      error_cnt = 0;
  integer      checked = 0;
  logic [7:0]  dtab [16] = '{8'h58, 8'hac, 8'h56, 8'hc6, 8'h30, 8'h30, 8'h18, 8'h36,
                             8'h00, 8'h00, 8'h00, 8'h00, 8'h18, 8'h18, 8'h0c, 8'h00};
  always #5 mclk = ~mclk;
  i2cfr_regs #(.HOLD_STD_NS(200), .HOLD_HS_NS(100)) i_dut (.mclk(mclk), .rst(rst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'h1), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .scl_in(scl_line), .scl_out(), .scl_oe(scl_oe), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
    .engine_release(engine_release), .start_done(start_done), .scl_divisor(scl_divisor),
    .filter_active(filter_active));
  i2cfr_bus_model i_bus (.mclk(mclk), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(scl_line),
    .sda_line(sda_line));
  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    begin
      $display("mismatches %0d comparisons %0d", error_cnt, checked);
      if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask
  // Request stands until waitrequest is sampled low at a rising edge; data is taken at that edge
  task automatic av(input logic wr, input logic [31:0] a, input logic [7:0] d, output logic [7:0] q);
    integer n;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    @(posedge mclk);
    while (avs_waitrequest && n < 50) begin
      @(posedge mclk);
      n++;
    end
    if (n == 50) begin
      error_cnt++;
      results;
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [7:0] q;
    av(1'b1, a, d, q);
  endtask
  task automatic rc(input string nm, input logic [31:0] a, input logic [7:0] e);
    logic [7:0] q;
    av(1'b0, a, 8'h0, q);
    chk(nm, q, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rc("flag", `I2CFR_IDX_FLAG, 8'h00);
    rc("clksel", `I2CFR_IDX_CLKSEL, 8'h00);
    rc("funcx", `I2CFR_IDX_FUNCX, 8'h00);
    wr(32'h0, 8'hff);
    rc("unmapped", 32'h0, 8'h00);
    wr(`I2CFR_IDX_FLAG, 8'hff);
    rc("flag ro", `I2CFR_IDX_FLAG, 8'h03);
    wr(`I2CFR_IDX_CLKSEL, 8'hff);
    rc("clksel ro", `I2CFR_IDX_CLKSEL, 8'h0f);
    wr(`I2CFR_IDX_FLAG, 8'h00);
  endtask
  task automatic t_divisor;
    for (int i = 0; i < 32; i++) begin
      wr(`I2CFR_IDX_FUNCX, {7'h0, i[4]});
      wr(`I2CFR_IDX_CLKSEL, {4'h0, i[3:0]});
      repeat (2) @(posedge mclk);
      chk("divisor", scl_divisor, dtab[{i[4], i[3], i[1:0]}]);
      chk("filter", filter_active, i[3] & i[2]);
    end
    wr(`I2CFR_IDX_FUNCX, 8'h00);
    wr(`I2CFR_IDX_CLKSEL, 8'h00);
  endtask
  // Clock enable low must freeze the divisor output until it returns
  task automatic t_freeze;
    wr(`I2CFR_IDX_CLKSEL, 8'h02);
    ce <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("frozen divisor", scl_divisor, 8'h58);
    ce <= 1'b1;
    repeat (2) @(posedge mclk);
    chk("thawed divisor", scl_divisor, 8'h56);
    wr(`I2CFR_IDX_CLKSEL, 8'h00);
  endtask
  task automatic t_fail;
    wr(`I2CFR_IDX_FLAG, 8'h01);
    wr(`I2CFR_IDX_CTRL, 8'h01);
    rc("busy on enable", `I2CFR_IDX_FLAG, 8'h41);
    wr(`I2CFR_IDX_CTRL, 8'h03);
    rc("fail set", `I2CFR_IDX_FLAG, 8'hc1);
    rc("trigger cleared", `I2CFR_IDX_CTRL, 8'h01);
    wr(`I2CFR_IDX_FLAG, 8'h02);
    rc("locked bits", `I2CFR_IDX_FLAG, 8'hc1);
    rc("line levels", `I2CFR_IDX_CLKSEL, 8'h30);
    i_bus.gen_stop();
    rc("busy cleared", `I2CFR_IDX_FLAG, 8'h81);
    wr(`I2CFR_IDX_CTRL, 8'h00);
    rc("disabled flag", `I2CFR_IDX_FLAG, 8'h01);
    rc("levels off", `I2CFR_IDX_CLKSEL, 8'h00);
  endtask
  task automatic t_start;
    integer n;
    wr(`I2CFR_IDX_FLAG, 8'h02);
    wr(`I2CFR_IDX_CTRL, 8'h01);
    rc("released", `I2CFR_IDX_FLAG, 8'h02);
    rc("bus idle", `I2CFR_IDX_CLKSEL, 8'h30);
    wr(`I2CFR_IDX_CTRL, 8'h03);
    n = 0;
    while (start_done !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk("start done", n < 200, 1'b1);
    if (n >= 200) results;
    chk("pins held", {scl_oe, sda_oe}, 2'b11);
    rc("own start", `I2CFR_IDX_FLAG, 8'h40);
    rc("start seen", `I2CFR_IDX_CTRL, 8'h05);
    @(posedge mclk);
    engine_release <= 1'b1;
    @(posedge mclk);
    engine_release <= 1'b0;
    i_bus.gen_stop();
    rc("after stop", `I2CFR_IDX_FLAG, 8'h00);
    wr(`I2CFR_IDX_CTRL, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_divisor;
    t_freeze;
    t_fail;
    t_start;
    results;
  end
endmodule // testbench
